// ### design/ref_clk_pkg.sv
// How it works
// (R1) With auto-select set, the block picks the group's reference link and ignores the index.
// (R2) With auto-select clear, the two-bit index names the group's reference link.
// (R3) Four reference-link control registers, one per group, sit at consecutive indices.
// (R4) The integration code sets a period of 2^(code+7) cycles, 2^7 for 0000 to 2^21 for 1110.
// (R5) Software never writes the all-ones integration code.
// (R6) Software should use 1100 for E1, 1011 for T1 with 24 channels, 1001 for T1 with 23.
// (R7) Direction clear: clock and sync are driven in modes 1 and 3, received in modes 2 and 4.
// (R8) Direction set: clock and sync are received in modes 5 and 7, driven in modes 6 and 8.
// (R9) Source codes 0000-0011 pick recovered receive clocks 0-3, 1000-1011 reference clocks 0-3.
// (R10) Bits 7 to 5 of each transmit clock control register read as zero.
// (R11) Bits 7 to 4 of integration registers and bit 7 of reference registers read as zero.
// (R12) Software writes zero to bit 2 of each reference-link control register.
// (R13) Four integration registers at indices 18c to 18f, each resetting to 05.
// (R14) Mode pairs map to line formats: T1 generic, T1 backplane, E1 generic, E1 backplane.
// (R15) The integration period counts system clocks and restarts at the end of each period.
// (R16) An unsupported source code leaves the previous clock source in use.
package ref_clk_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] TXCTL_IDX = 10'h080;
	localparam logic [9:0] REFSEL_IDX = 10'h188;
	localparam logic [9:0] INTEG_IDX = 10'h18c;
	localparam logic [9:0] FMT_IDX = 10'h0a0;
	// Values after reset
	localparam logic [7:0] TXCTL_RST = 8'h00;
	localparam logic [7:0] REFSEL_RST = 8'h00;
	localparam logic [7:0] INTEG_RST = 8'h05;
	localparam logic [7:0] FMT_RST = 8'h00;
	// Field positions
	localparam int DIR_BIT = 4;
	localparam int AUTO_BIT = 3;
	localparam int SRC_BANK_BIT = 3;
	localparam int SRC_BAD_BIT = 2;
	// Integration timing
	localparam int PERIOD_W = 22;
	localparam int INTEG_BASE = 7;
	localparam logic [3:0] INTEG_MAX_CODE = 4'he;
	// Line formats held in the format register (mode pairs 1/5, 2/6, 3/7, 4/8)
	typedef enum logic [1:0] {
		FMT_T1_GENERIC,
		FMT_T1_BACKPLANE,
		FMT_E1_GENERIC,
		FMT_E1_BACKPLANE
	} line_fmt_e;
endpackage : ref_clk_pkg

// ### design/integration_timer.sv
`timescale 1ns/1ps
// Free-running period counter for one group; tick marks each period end
module integration_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Period code
	input wire logic [3:0] code,
	// Period end
	output logic tick
);
	logic [ref_clk_pkg::PERIOD_W-1:0] cnt_r;
	logic [ref_clk_pkg::PERIOD_W-1:0] cnt_nxt;
	wire [3:0] code_use;
	wire [ref_clk_pkg::PERIOD_W-1:0] last;
	wire at_end;

	// Last count of a 2^(code+7) period; reserved code clamps to the longest period
	function automatic logic [ref_clk_pkg::PERIOD_W-1:0] period_last(input logic [3:0] c);
		logic [ref_clk_pkg::PERIOD_W:0] one;
		one = '0;
		one[c + ref_clk_pkg::INTEG_BASE] = 1'b1;
		period_last = ref_clk_pkg::PERIOD_W'(one - 1'b1);
	endfunction : period_last

	// Period decode
	assign code_use = (code > ref_clk_pkg::INTEG_MAX_CODE) ? ref_clk_pkg::INTEG_MAX_CODE : code;
	assign last = period_last(code_use); // [R4]
	assign at_end = (cnt_r >= last); // A shortened code ends the running period at once
	assign cnt_nxt = at_end ? '0 : cnt_r + 1'b1; // [R15]

	// Counter and tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= at_end;
		end
	end

	chk_period_restart: assert property (@(posedge clk) disable iff (!rst_n)
		tick |-> cnt_r == '0) else $error("count did not restart at period end"); // [R15]
	chk_period_length: assert property (@(posedge clk) disable iff (!rst_n)
		(code == 4'h0 && cnt_r == 22'h00007f) |=> tick)
		else $error("shortest period not 128 cycles"); // [R4]
endmodule : integration_timer

// ### design/link_clock_port.sv
`timescale 1ns/1ps
// Line-side clock and sync driver for one transmit link, on the line clock
module link_clock_port (
	// Line clock and reset
	input wire logic line_clk,
	input wire logic line_rst_n,
	// Settings from the register side: {drive, bank, select[1:0]}
	input wire logic [3:0] cfg,
	// Synchronised candidate clocks: [3:0] recovered, [7:4] reference
	input wire logic [7:0] src_lvl,
	// Frame sync from the transmitter
	input wire logic sync_gen,
	// Pins
	output logic clk_o,
	output logic clk_oe,
	output logic sync_o,
	output logic sync_oe
);
	logic [3:0] cfg_s1_r;
	logic [3:0] cfg_s2_r;
	logic [3:0] cfg_s3_r;
	logic [3:0] cfg_use_r;
	wire cfg_steady;
	wire [2:0] pick;

	// Settings are static words; take them only once two samples agree
	// Only the settled stages are compared; the first flop feeds the second alone
	assign cfg_steady = (cfg_s3_r == cfg_s2_r);
	assign pick = cfg_use_r[2:0];

	always_ff @(posedge line_clk) begin
		if (!line_rst_n) begin
			cfg_s1_r <= '0;
			cfg_s2_r <= '0;
			cfg_s3_r <= '0;
			cfg_use_r <= '0;
		end else begin
			cfg_s1_r <= cfg;
			cfg_s2_r <= cfg_s1_r;
			cfg_s3_r <= cfg_s2_r;
			if (cfg_steady) begin
				cfg_use_r <= cfg_s3_r;
			end
		end
	end

	// Drive pins from flops; enables follow the mode and direction
	always_ff @(posedge line_clk) begin
		if (!line_rst_n) begin
			clk_o <= 1'b0;
			clk_oe <= 1'b0;
			sync_o <= 1'b0;
			sync_oe <= 1'b0;
		end else begin
			clk_o <= src_lvl[pick]; // [R9]
			clk_oe <= cfg_use_r[3]; // [R7] [R8]
			sync_o <= sync_gen;
			sync_oe <= cfg_use_r[3]; // [R7] [R8]
		end
	end

	chk_pin_follows: assert property (@(posedge line_clk) disable iff (!line_rst_n)
		1'b1 |=> clk_o == $past(src_lvl[pick])) else $error("tx clock not from source"); // [R9]
	chk_pins_together: assert property (@(posedge line_clk) disable iff (!line_rst_n)
		clk_oe == sync_oe) else $error("clock and sync directions differ"); // [R7]
endmodule : link_clock_port

// ### design/ref_link_and_tx_clock_ctrl.sv
`timescale 1ns/1ps
// Reference-link choice, integration periods and transmit line clock control
module ref_link_and_tx_clock_ctrl (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Line clock and its reset
	input wire logic line_clk,
	input wire logic line_rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive link status, system clock domain
	input wire logic [3:0] link_up,
	// Per-group results
	output logic [7:0] ref_link,
	output logic [3:0] integration_tick,
	// Candidate clocks, asynchronous
	input wire logic [3:0] recovered_rx_clock,
	input wire logic [3:0] reference_clock,
	// Transmitter frame timing, line clock domain
	input wire logic [3:0] frame_sync_gen,
	// Transmit line pins, one bit per link
	input wire logic [3:0] tx_line_clock_i,
	output logic [3:0] tx_line_clock_o,
	output logic [3:0] tx_line_clock_oe,
	input wire logic [3:0] tx_frame_sync_i,
	output logic [3:0] tx_frame_sync_o,
	output logic [3:0] tx_frame_sync_oe,
	// Sensed line inputs when received, system clock domain
	output logic [3:0] tx_line_clock_seen,
	output logic [3:0] tx_frame_sync_seen
);
	// Register storage
	logic [4:0] txctl_r [4];
	logic [3:0] refsel_r [4];
	logic [3:0] integ_r [4];
	logic [1:0] fmt_r [4];
	logic [2:0] src_eff_r [4];
	logic [7:0] ref_link_nxt;
	logic [7:0] rd_byte;
	logic [7:0] lvl_s1_r;
	logic [7:0] lvl_s2_r;
	logic [7:0] seen_s1_r;
	logic [7:0] seen_s2_r;
	logic [3:0] drive;

	// Lowest-numbered link that is up; link 0 when none is
	function automatic logic [1:0] first_up(input logic [3:0] up);
		first_up = up[0] ? 2'd0 : up[1] ? 2'd1 : up[2] ? 2'd2 : up[3] ? 2'd3 : 2'd0;
	endfunction : first_up

	// Address decode; byte address is four times the index
	wire [9:0] idx = paddr[11:2];
	wire [1:0] unit = idx[1:0];
	wire hit_tx = (idx[9:2] == ref_clk_pkg::TXCTL_IDX[9:2]);
	wire hit_ref = (idx[9:2] == ref_clk_pkg::REFSEL_IDX[9:2]); // [R3]
	wire hit_integ = (idx[9:2] == ref_clk_pkg::INTEG_IDX[9:2]); // [R13]
	wire hit_fmt = (idx[9:2] == ref_clk_pkg::FMT_IDX[9:2]);
	wire hit_any = hit_tx || hit_ref || hit_integ || hit_fmt;
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pready && pwrite && hit_any;
	wire [3:0] wr_src = pwdata[3:0];
	wire src_ok = !wr_src[ref_clk_pkg::SRC_BANK_BIT-1] || !wr_src[ref_clk_pkg::SRC_BAD_BIT]
		? !wr_src[ref_clk_pkg::SRC_BAD_BIT] : 1'b0;
	wire [2:0] src_pick = {wr_src[ref_clk_pkg::SRC_BANK_BIT], wr_src[1:0]};
	wire auto_pick_0 = refsel_r[0][ref_clk_pkg::AUTO_BIT];

	// Read mux; unused bits read as zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit_tx) begin
			rd_byte = {3'h0, txctl_r[unit]}; // [R10]
		end else if (hit_ref) begin
			rd_byte = {4'h0, refsel_r[unit]}; // [R11]
		end else if (hit_integ) begin
			rd_byte = {4'h0, integ_r[unit]}; // [R11]
		end else if (hit_fmt) begin
			rd_byte = {6'h00, fmt_r[unit]};
		end
	end

	// APB answer: data taken in setup, one access cycle with no wait states
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !hit_any; // Unmapped word answers with an error
			if (setup && !pwrite) begin
				prdata <= {24'h000000, rd_byte};
			end
		end
	end

	// Register writes; the effective source only moves on a supported code
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				txctl_r[i] <= ref_clk_pkg::TXCTL_RST[4:0];
				refsel_r[i] <= ref_clk_pkg::REFSEL_RST[3:0];
				integ_r[i] <= ref_clk_pkg::INTEG_RST[3:0]; // [R13]
				fmt_r[i] <= ref_clk_pkg::FMT_RST[1:0];
				src_eff_r[i] <= 3'h0;
			end
		end else if (wr_go) begin
			if (hit_tx) begin
				txctl_r[unit] <= pwdata[4:0];
				if (src_ok) begin
					src_eff_r[unit] <= src_pick; // [R9] [R16]
				end
			end
			if (hit_ref) begin
				refsel_r[unit] <= pwdata[3:0]; // Bit 2 stored as written
			end
			if (hit_integ) begin
				integ_r[unit] <= pwdata[3:0];
			end
			if (hit_fmt) begin
				fmt_r[unit] <= pwdata[1:0];
			end
		end
	end

	// Reference link per group: automatic pick or the fixed index
	always_comb begin
		ref_link_nxt = 8'h00;
		for (int g = 0; g < 4; g++) begin
			ref_link_nxt[2*g +: 2] = refsel_r[g][ref_clk_pkg::AUTO_BIT]
				? first_up(link_up) // [R1]
				: refsel_r[g][1:0]; // [R2]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_link <= 8'h00;
		end else begin
			ref_link <= ref_link_nxt;
		end
	end

	// One period timer per group
	for (genvar g = 0; g < 4; g++) begin : g_integ
		integration_timer u_timer (
			.clk(clk),
			.rst_n(rst_n),
			.code(integ_r[g]),
			.tick(integration_tick[g])
		);
	end

	// Pins driven when direction and format agree: generic modes with direction
	// clear, backplane modes with direction set
	always_comb begin
		for (int l = 0; l < 4; l++) begin
			drive[l] = !(txctl_r[l][ref_clk_pkg::DIR_BIT] ^ fmt_r[l][0]); // [R7] [R8] [R14]
		end
	end

	// Candidate clocks are asynchronous; two flops before the selectors
	always_ff @(posedge line_clk) begin
		if (!line_rst_n) begin
			lvl_s1_r <= 8'h00;
			lvl_s2_r <= 8'h00;
		end else begin
			lvl_s1_r <= {reference_clock, recovered_rx_clock};
			lvl_s2_r <= lvl_s1_r;
		end
	end

	// Per-link line drivers on the line clock
	for (genvar l = 0; l < 4; l++) begin : g_link
		link_clock_port u_port (
			.line_clk(line_clk),
			.line_rst_n(line_rst_n),
			.cfg({drive[l], src_eff_r[l]}),
			.src_lvl(lvl_s2_r),
			.sync_gen(frame_sync_gen[l]),
			.clk_o(tx_line_clock_o[l]),
			.clk_oe(tx_line_clock_oe[l]),
			.sync_o(tx_frame_sync_o[l]),
			.sync_oe(tx_frame_sync_oe[l])
		);
	end

	// Received clock and sync levels brought to the system clock, masked when driving
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_s1_r <= 8'h00;
			seen_s2_r <= 8'h00;
			tx_line_clock_seen <= 4'h0;
			tx_frame_sync_seen <= 4'h0;
		end else begin
			seen_s1_r <= {tx_frame_sync_i, tx_line_clock_i};
			seen_s2_r <= seen_s1_r;
			// Outputs from flops; driven links report zero
			tx_line_clock_seen <= seen_s2_r[3:0] & ~drive;
			tx_frame_sync_seen <= seen_s2_r[7:4] & ~drive;
		end
	end

	chk_auto_ref: assert property (@(posedge clk) disable iff (!rst_n)
		auto_pick_0 |=> ref_link[1:0] == first_up($past(link_up)))
		else $error("automatic reference pick wrong"); // [R1]
	chk_manual_ref: assert property (@(posedge clk) disable iff (!rst_n)
		!auto_pick_0 |=> ref_link[1:0] == $past(refsel_r[0][1:0]))
		else $error("manual reference index not used"); // [R2]
	chk_tx_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(setup && !pwrite && hit_tx) |=> prdata[7:5] == 3'h0)
		else $error("transmit control upper bits not zero"); // [R10]
	chk_integ_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(setup && !pwrite && (hit_integ || hit_ref)) |=> prdata[7] == 1'b0 && (!$past(hit_integ)
		|| prdata[7:4] == 4'h0)) else $error("integration upper bits not zero"); // [R11]
	chk_src_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_go && hit_tx && wr_src[ref_clk_pkg::SRC_BAD_BIT] && unit == 2'd0)
		|=> $stable(src_eff_r[0]))
		else $error("unsupported source code changed source"); // [R16]
	chk_apb_ready: assert property (@(posedge clk) disable iff (!rst_n)
		setup |=> pready ##1 !pready) else $error("ready not one access cycle");
	chk_integ_reset: assert property (@(posedge clk)
		!rst_n |=> integ_r[3] == 4'h5 && integ_r[0] == 4'h5)
		else $error("integration reset value wrong"); // [R13]
endmodule : ref_link_and_tx_clock_ctrl

// ### tb/framer_model.sv
`timescale 1ns/1ps
// Line-side framer for four links: supplies clock and sync where the device receives
module framer_model (
	// Line clock
	input wire logic line_clk,
	// Device pin drivers
	input wire logic [3:0] clk_o,
	input wire logic [3:0] clk_oe,
	input wire logic [3:0] sync_o,
	input wire logic [3:0] sync_oe,
	// Resolved pin levels
	output logic [3:0] clk_pin,
	output logic [3:0] sync_pin
);
	logic [3:0] div_r = 4'h0;
	// Own timing: clock at a quarter of the line clock, sync once in sixteen
	always_ff @(posedge line_clk) begin
		div_r <= div_r + 4'h1;
	end
	// Framer drives only links that the device leaves as inputs
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			clk_pin[i] = clk_oe[i] ? clk_o[i] : div_r[1];
			sync_pin[i] = sync_oe[i] ? sync_o[i] : (div_r == 4'hf);
		end
	end
endmodule : framer_model

// ### tb/ref_link_and_tx_clock_ctrl_tb.sv
`timescale 1ns/1ps
// Register, reference-link, integration and transmit clock checks
module ref_link_and_tx_clock_ctrl_tb;
	typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic line_clk = 1'b0;
	logic line_rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] link_up = 4'h0;
	logic [3:0] rec_clk = 4'h0;
	logic [3:0] ref_clk = 4'h0;
	logic [3:0] fsync_gen = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] ref_link;
	logic [3:0] tick;
	logic [3:0] clk_o, clk_oe, sync_o, sync_oe, clk_pin, sync_pin, seen_c, seen_s;
	logic [31:0] q;
	logic e;
	int n;
	int err_total = 0;
	int total_checks = 0;
	// Ordinary cases: address, write value, readback, error expected
	row_s rows [4] = '{
		'{12'h200, 8'hff, 8'h1f, 1'b0},
		'{12'h62c, 8'h8b, 8'h0b, 1'b0},
		'{12'h634, 8'hf3, 8'h03, 1'b0},
		'{12'h100, 8'h5a, 8'h00, 1'b1}};
	// Clocks: edges of the two coincide every 400 ns
	always #50 clk = ~clk;
	always #80 line_clk = ~line_clk;
	always @(posedge line_clk) fsync_gen <= fsync_gen + 4'h1;

	ref_link_and_tx_clock_ctrl dut_u (.clk(clk), .rst_n(rst_n), .line_clk(line_clk),
		.line_rst_n(line_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_up(link_up), .ref_link(ref_link), .integration_tick(tick),
		.recovered_rx_clock(rec_clk), .reference_clock(ref_clk), .frame_sync_gen(fsync_gen),
		.tx_line_clock_i(clk_pin), .tx_line_clock_o(clk_o), .tx_line_clock_oe(clk_oe),
		.tx_frame_sync_i(sync_pin), .tx_frame_sync_o(sync_o), .tx_frame_sync_oe(sync_oe),
		.tx_line_clock_seen(seen_c), .tx_frame_sync_seen(seen_s));
	framer_model fr_u (.line_clk(line_clk), .clk_o(clk_o), .clk_oe(clk_oe), .sync_o(sync_o),
		.sync_oe(sync_oe), .clk_pin(clk_pin), .sync_pin(sync_pin));

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1
	// Let the line side settle, then sample away from its edges
	task automatic wline();
		repeat (8) @(posedge line_clk);
		#1;
	endtask : wline
	// Cycles between two consecutive ticks of one group
	task automatic gap(input int b, output int c);
		while (tick[b] !== 1'b1) @(posedge clk);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (tick[b] !== 1'b1 && c < 5000);
	endtask : gap
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// Watchdog: the run needs well under this
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	// Main sequence
	initial begin
		logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b};
		logic x;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		line_rst_n <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			apb(1'b0, 12'h200 + 12'(4 * g), 32'h0);
			chk(q, 32'h0);
			apb(1'b0, 12'h620 + 12'(4 * g), 32'h0);
			chk(q, 32'h0);
			apb(1'b0, 12'h630 + 12'(4 * g), 32'h0);
			chk(q, 32'h05);
		end
		$display("reset values done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, {24'h0, rows[i].w});
			chk1(e, rows[i].e);
			apb(1'b0, rows[i].a, 32'h0);
			chk(q, {24'h0, rows[i].r});
		end
		$display("table done");
		// Manual index, then automatic pick on group 0, bit 2 kept at zero
		for (int g = 0; g < 4; g++) apb(1'b1, 12'h620 + 12'(4 * g), 32'(3 - g));
		repeat (2) @(posedge clk);
		chk({24'h0, ref_link}, 32'h1b);
		@(posedge clk);
		link_up <= 4'b1100;
		apb(1'b1, 12'h620, 32'h0b);
		repeat (2) @(posedge clk);
		chk({24'h0, ref_link}, 32'h1a);
		$display("reference link done");
		// Short periods; never the reserved code
		for (int c = 0; c < 2; c++) begin
			apb(1'b1, 12'h630 + 12'(4 * c), 32'(c));
			gap(c, n);
			chk(32'(n), 32'(1 << (c + 7)));
		end
		$display("integration done");
		for (int f = 0; f < 4; f++) begin
			for (int d = 0; d < 2; d++) begin
				apb(1'b1, 12'h280, 32'(f));
				apb(1'b1, 12'h200, 32'(d << 4));
				wline();
				x = !(d[0] ^ f[0]);
				chk1(clk_oe[0], x);
				chk1(sync_oe[0], x);
				chk1(sync_o[0], ~fsync_gen[0]);
				if (x) chk1(seen_c[0], 1'b0);
			end
		end
		$display("direction done");
		apb(1'b1, 12'h280, 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h200, {24'h0, codes[i]});
			@(posedge clk);
			{ref_clk, rec_clk} <= 8'h01 << i;
			wline();
			chk1(clk_o[0], 1'b1);
			@(posedge clk);
			{ref_clk, rec_clk} <= ~(8'h01 << i);
			wline();
			chk1(clk_o[0], 1'b0);
		end
		apb(1'b1, 12'h200, 32'h04);
		@(posedge clk);
		{ref_clk, rec_clk} <= 8'h80;
		wline();
		chk1(clk_o[0], 1'b1);
		apb(1'b0, 12'h200, 32'h0);
		chk(q, 32'h04);
		$display("source select done");
		wrap_up();
	end
endmodule : ref_link_and_tx_clock_ctrl_tb
